// ---- rtl/tvr_pkg.sv ----
// Purpose: Shared constants of the timer value register block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: Offsets are byte addresses
package tvr_pkg;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int TVR_CW = 16;
    localparam int TVR_AW = 8;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EVENT = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h24;
    localparam logic [7:0] OFS_DIV = 8'h28;
    localparam logic [7:0] OFS_RELOAD = 8'h2C;
    localparam logic [7:0] OFS_CH0 = 8'h34;
    localparam logic [7:0] OFS_CH1 = 8'h38;
    localparam logic [7:0] OFS_CFG = 8'hFC;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MODE0_LSB = 1;
    localparam int CTRL_MODE1_LSB = 3;
    localparam int CTRL_SHEN0_BIT = 5;
    localparam int CTRL_SHEN1_BIT = 6;
    localparam int CTRL_W = 7;
    localparam int EVENT_UPD_BIT = 0;
    localparam int CFG_FILTER_BIT = 1;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [15:0] RST_VAL16 = 16'h0000;
    localparam logic [6:0] RST_CTRL = 7'h00;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage

// ---- rtl/tvr_prescaler.sv ----
// Purpose: Counter clock divider with update-loaded shadow ratio
// Assumes: Same clock as the register file
// Notes: tick is a one-cycle pulse per counter step
`timescale 1ns/1ps
module tvr_prescaler
    import tvr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic restart,
    input wire logic upd,
    input wire logic [TVR_CW-1:0] divider,
    output logic tick
);
    logic [TVR_CW-1:0] shadow;
    logic [TVR_CW-1:0] pcnt;
    logic [TVR_CW-1:0] next_pcnt;
    wire at_end = (pcnt >= shadow);

    // ----------------------------------------
    // Divide by shadow + 1
    // ----------------------------------------
    assign next_pcnt = (restart || !run || at_end) ? RST_VAL16 : pcnt + 16'h0001;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            shadow <= RST_VAL16;
            pcnt <= RST_VAL16;
        end else begin
            pcnt <= next_pcnt;
            if (upd) begin
                shadow <= divider;
            end
        end
    end
    assign tick = run && !restart && at_end;

    a_shadow_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !upd |=> $stable(shadow)) else $error("divider shadow moved without update");
    a_tick_space: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tick && shadow != 16'h0000 && !upd) |=> !tick) else $error("ticks too close");
endmodule // tvr_prescaler

// ---- rtl/tvr_channel.sv ----
// Purpose: One capture/compare channel value register
// Assumes: cap_pin is asynchronous to core_clk
// Notes: Capture on rising edge of the filtered pin
`timescale 1ns/1ps
module tvr_channel
    import tvr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [TVR_CW-1:0] wr_data,
    input wire logic filter_on,
    input wire logic [1:0] mode,
    input wire logic shadow_en,
    input wire logic upd,
    input wire logic cap_pin,
    input wire logic [TVR_CW-1:0] count,
    output logic [TVR_CW-1:0] value,
    output logic match
);
    logic s1, s2, s3, level;
    logic [TVR_CW-1:0] active;
    wire in_mode = (mode != 2'b00);
    wire cap = in_mode && (s2 == s3) && s3 && !level;
    // Redundant writes dropped so compare timing is not disturbed
    wire wr_ok = wr_en && !in_mode && !(filter_on && wr_data == value);
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            {s1, s2, s3, level} <= 4'h0;
            value <= RST_VAL16;
            active <= RST_VAL16;
            match <= 1'b0;
        end else begin
            s1 <= cap_pin;
            s2 <= s1;
            s3 <= s2;
            level <= (s2 == s3) ? s3 : level;
            if (cap) begin
                value <= count;
            end else if (wr_ok) begin
                value <= wr_data;
            end
            if (!shadow_en || upd) begin
                active <= value;
            end
            match <= !in_mode && (count == active);
        end
    end

    a_shadow_wait: assert property (@(posedge core_clk) disable iff (!rst_b)
        (shadow_en && !upd) |=> $stable(active)) else $error("compare shadow moved early");
    a_input_lock: assert property (@(posedge core_clk) disable iff (!rst_b)
        (in_mode && !cap) |=> $stable(value)) else $error("value changed in input mode");
endmodule // tvr_channel

// ---- rtl/tvr_timer.sv ----
// Purpose: Value registers of a two-channel 16-bit up counter
// Assumes: Avalon-MM slave with waitrequest, 32-bit words
// Notes: Every access answers in two cycles
`timescale 1ns/1ps
module tvr_timer
    import tvr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [TVR_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [1:0] cap_pin,
    output logic [1:0] cmp_match,
    output logic update_pulse
);
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic [TVR_CW-1:0] count_field;
    logic [TVR_CW-1:0] divider_field;
    logic [TVR_CW-1:0] reload_field;
    logic same_value_write_filter;
    logic [CTRL_W-1:0] ctrl;
    logic [TVR_CW-1:0] chan0_value_field;
    logic [TVR_CW-1:0] chan1_value_field;
    logic [TVR_CW-1:0] next_count;
    logic [31:0] next_rdata;
    logic tick;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    // Waitrequest drops one cycle after the request is seen
    wire req = avs_read || avs_write;
    wire accept = req && !avs_waitrequest;
    wire wr = accept && avs_write;
    // Only the low half is stored, so lanes 1:0 must be enabled
    wire lo_lanes = (avs_byteenable[1:0] == 2'b11);
    wire wr16 = wr && lo_lanes;

    wire wr_count = wr16 && hit(avs_address, OFS_COUNT);
    wire wr_div = wr16 && hit(avs_address, OFS_DIV);
    wire wr_reload = wr16 && hit(avs_address, OFS_RELOAD);
    wire wr_ch0 = wr16 && hit(avs_address, OFS_CH0);
    wire wr_ch1 = wr16 && hit(avs_address, OFS_CH1);
    wire wr_cfg = wr && avs_byteenable[0] && hit(avs_address, OFS_CFG);
    wire wr_ctrl = wr && avs_byteenable[0] && hit(avs_address, OFS_CTRL);
    wire upd_sw = wr && avs_byteenable[0] && hit(avs_address, OFS_EVENT)
        && avs_writedata[EVENT_UPD_BIT];

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    wire run = ctrl[CTRL_RUN_BIT];
    wire [1:0] mode0 = ctrl[CTRL_MODE0_LSB +: 2];
    wire [1:0] mode1 = ctrl[CTRL_MODE1_LSB +: 2];
    wire shen0 = ctrl[CTRL_SHEN0_BIT];
    wire shen1 = ctrl[CTRL_SHEN1_BIT];

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    wire wrap = tick && (count_field >= reload_field);
    wire upd = upd_sw || wrap;
    // Software load wins over a wrap in the same cycle
    assign next_count = wr_count ? avs_writedata[15:0]
        : (upd_sw || wrap) ? RST_VAL16
        : tick ? count_field + 16'h0001
        : count_field;

    tvr_prescaler u_presc (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(run),
        .restart(upd_sw || wr_count),
        .upd(upd),
        .divider(divider_field),
        .tick(tick)
    );

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    tvr_channel u_ch0 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_en(wr_ch0),
        .wr_data(avs_writedata[15:0]),
        .filter_on(same_value_write_filter),
        .mode(mode0),
        .shadow_en(shen0),
        .upd(upd),
        .cap_pin(cap_pin[0]),
        .count(count_field),
        .value(chan0_value_field),
        .match(cmp_match[0])
    );

    tvr_channel u_ch1 (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .wr_en(wr_ch1),
        .wr_data(avs_writedata[15:0]),
        .filter_on(same_value_write_filter),
        .mode(mode1),
        .shadow_en(shen1),
        .upd(upd),
        .cap_pin(cap_pin[1]),
        .count(count_field),
        .value(chan1_value_field),
        .match(cmp_match[1])
    );

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    // Unmapped addresses read as zero
    assign next_rdata =
        hit(avs_address, OFS_COUNT) ? {16'h0000, count_field}
        : hit(avs_address, OFS_DIV) ? {16'h0000, divider_field}
        : hit(avs_address, OFS_RELOAD) ? {16'h0000, reload_field}
        : hit(avs_address, OFS_CH0) ? {16'h0000, chan0_value_field}
        : hit(avs_address, OFS_CH1) ? {16'h0000, chan1_value_field}
        : hit(avs_address, OFS_CFG) ? {30'h0000_0000, same_value_write_filter, 1'b0}
        : hit(avs_address, OFS_CTRL) ? {25'h000_0000, ctrl}
        : RST_RDATA;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= RST_RDATA;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            count_field <= RST_VAL16;
            divider_field <= RST_VAL16;
            reload_field <= RST_VAL16;
            same_value_write_filter <= 1'b0;
            ctrl <= RST_CTRL;
            update_pulse <= 1'b0;
        end else begin
            count_field <= next_count;
            update_pulse <= upd;
            if (wr_div) begin
                divider_field <= avs_writedata[15:0];
            end
            if (wr_reload) begin
                reload_field <= avs_writedata[15:0];
            end
            if (wr_cfg) begin
                same_value_write_filter <= avs_writedata[CFG_FILTER_BIT];
            end
            if (wr_ctrl) begin
                ctrl <= avs_writedata[CTRL_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_count_read: assert property (@(posedge core_clk) disable iff (!rst_b)
        (avs_read && avs_waitrequest && hit(avs_address, OFS_COUNT))
        |=> avs_readdata == {16'h0000, $past(count_field)}) else $error("count read wrong");
    a_count_load: assert property (@(posedge core_clk) disable iff (!rst_b)
        wr_count |=> count_field == $past(avs_writedata[15:0])) else $error("count not loaded");
    a_reload_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wrap && !wr_count) |=> count_field == 16'h0000) else $error("no wrap at limit");
    a_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        avs_readdata[31:16] == 16'h0000) else $error("upper read bits set");
    a_filter_drop: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_ch0 && same_value_write_filter && mode0 == 2'b00
        && avs_writedata[15:0] == chan0_value_field)
        |=> $stable(chan0_value_field)) else $error("equal write not dropped");
    a_value_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_ch1 && mode1 == 2'b00 && !same_value_write_filter)
        |=> chan1_value_field == $past(avs_writedata[15:0])) else $error("value write lost");
    a_input_block: assert property (@(posedge core_clk) disable iff (!rst_b)
        (wr_ch0 && mode0 != 2'b00 && !u_ch0.cap)
        |=> $stable(chan0_value_field)) else $error("write passed in input mode");
    a_reset_clear: assert property (@(posedge core_clk)
        !rst_b |=> (count_field == 16'h0000 && divider_field == 16'h0000
        && reload_field == 16'h0000 && !same_value_write_filter
        && chan0_value_field == 16'h0000 && chan1_value_field == 16'h0000))
        else $error("reset did not clear");
    a_bus_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
        (req && avs_waitrequest && $stable(avs_address)) |=> !avs_waitrequest)
        else $error("no answer in one cycle");
endmodule // tvr_timer

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench of the timer value register block
// Assumes: Avalon-MM slave with waitrequest, one clock
// Notes: Count windows allow a few cycles for prescaler phase
`timescale 1ns/1ps
module tb_top
    import tvr_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] cap_pin = 2'b00;
    logic [1:0] cmp_match;
    logic update_pulse;
    int errors = 0;
    int checked = 0;
    int pulses;
    int mv [4];
    logic [31:0] seed = 32'h0001_28B0;
    logic [31:0] q;
    logic [7:0] adr [4] = '{OFS_DIV, OFS_RELOAD, OFS_CH0, OFS_CH1};
    logic [7:0] rst_adr [8] = '{OFS_COUNT, OFS_DIV, OFS_RELOAD, OFS_CH0, OFS_CH1, OFS_CFG, OFS_EVENT, 8'h40};
    always #12.5 core_clk = ~core_clk;
    tvr_timer DUT (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cap_pin(cap_pin),
        .cmp_match(cmp_match), .update_pulse(update_pulse));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tally_and_finish;
        $display("Counts: %0d compared, %0d mismatched", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until the rising edge that samples waitrequest low; data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
        output logic [31:0] rq);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            errors++;
            tally_and_finish();
        end
        rq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [31:0] dq;
        bus(1'b1, a, {16'h0000, v}, 4'hF, dq);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] dq;
        bus(1'b0, a, 32'h0000_0000, 4'hF, dq);
        check(dq, exp);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] dq);
        bus(1'b0, a, 32'h0000_0000, 4'hF, dq);
    endtask
    task automatic run_for(input logic [15:0] ctrl, input int w);
        wr(OFS_CTRL, ctrl | 16'h0001);
        repeat (w) @(posedge core_clk);
        wr(OFS_CTRL, ctrl);
    endtask
    task automatic in_range(input logic [31:0] v, input int lo, input int hi);
        check(32'(v >= lo && v <= hi), 32'h0000_0001);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        foreach (rst_adr[i]) rdc(rst_adr[i], 32'h0000_0000);
        $display("Test reset values done");
        foreach (mv[i]) mv[i] = 0;
        for (int k = 0; k < 12; k++) begin
            seed = lfsr(seed);
            bus(1'b1, adr[k % 4], {16'h0000, seed[15:0]}, 4'hF, q);
            if (!(k % 4 >= 2 && seed[15:0] == mv[k % 4][15:0])) mv[k % 4] = seed[15:0];
            rdc(adr[k % 4], mv[k % 4]);
        end
        bus(1'b1, OFS_RELOAD, 32'h0000_FFFF, 4'hC, q);
        rdc(OFS_RELOAD, mv[1]);
        seed = lfsr(seed);
        bus(1'b1, OFS_CFG, 32'h0000_0002, 4'hF, q);
        rdc(OFS_CFG, 32'h0000_0002);
        $display("Test register access done");
        wr(OFS_CH0, mv[2][15:0]);
        rdc(OFS_CH0, mv[2]);
        wr(OFS_CH0, 16'h0123);
        rdc(OFS_CH0, 32'h0000_0123);
        wr(OFS_CFG, 16'h0000);
        $display("Test write filter done");
        wr(OFS_COUNT, 16'hA5C3);
        rdc(OFS_COUNT, 32'h0000_A5C3);
        wr(OFS_DIV, 16'h0000);
        wr(OFS_EVENT, 16'h0001);
        wr(OFS_RELOAD, 16'hFFFF);
        wr(OFS_DIV, 16'h0003);
        run_for(16'h0000, 40);
        rd(OFS_COUNT, q);
        in_range(q, 40, 46);
        wr(OFS_EVENT, 16'h0001);
        run_for(16'h0000, 40);
        rd(OFS_COUNT, q);
        in_range(q, 9, 13);
        $display("Test divider done");
        wr(OFS_DIV, 16'h0000);
        wr(OFS_EVENT, 16'h0001);
        wr(OFS_RELOAD, 16'h0005);
        wr(OFS_CTRL, 16'h0001);
        pulses = 0;
        repeat (60) begin
            @(negedge core_clk);
            pulses += int'(update_pulse === 1'b1);
        end
        in_range(pulses, 8, 12);
        repeat (4) begin
            rd(OFS_COUNT, q);
            in_range(q, 0, 5);
        end
        wr(OFS_CTRL, 16'h0000);
        $display("Test reload limit done");
        wr(OFS_COUNT, 16'h0123);
        repeat (3) @(negedge core_clk);
        check(cmp_match[0], 1'b1);
        wr(OFS_COUNT, 16'h0124);
        repeat (3) @(negedge core_clk);
        check(cmp_match[0], 1'b0);
        wr(OFS_CTRL, 16'h0020);
        wr(OFS_CH0, 16'h0200);
        wr(OFS_COUNT, 16'h0200);
        repeat (3) @(negedge core_clk);
        check(cmp_match[0], 1'b0);
        wr(OFS_EVENT, 16'h0001);
        wr(OFS_COUNT, 16'h0200);
        repeat (3) @(negedge core_clk);
        check(cmp_match[0], 1'b1);
        rdc(OFS_CH0, 32'h0000_0200);
        $display("Test compare done");
        wr(OFS_CTRL, 16'h0008);
        wr(OFS_COUNT, 16'h0345);
        wr(OFS_CH1, mv[3][15:0] ^ 16'h7777);
        rdc(OFS_CH1, mv[3]);
        @(posedge core_clk);
        cap_pin <= 2'b10;
        repeat (10) @(posedge core_clk);
        cap_pin <= 2'b00;
        rdc(OFS_CH1, 32'h0000_0345);
        check(cmp_match[1], 1'b0);
        $display("Test capture done");
        tally_and_finish();
    end
endmodule // tb_top
